// ==== pkg/awfa_pkg.sv ====
`default_nettype none
package awfa_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WORK  = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_FADDR = 8'h0C;
  localparam logic [7:0] OFS_FDATA = 8'h10;
  // ****************************************
  // flag fields
  // ****************************************
  localparam int FLG_C    = 0;
  localparam int FLG_DC   = 1;
  localparam int FLG_Z    = 2;
  localparam int FLG_OV   = 3;
  localparam int FLG_BUSY = 8;
  localparam int FLG_BAD  = 9;
  localparam logic [3:0]  FLAGS_RST = 4'h0;
  localparam logic [7:0]  WORK_RST  = 8'h00;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  // ****************************************
  // opcodes and bus answers
  // ****************************************
  localparam logic [3:0] OP_ADD_HI  = 4'h0;
  localparam logic [2:0] OP_ADD_MID = 3'h7;
  localparam logic [3:0] OP_ADC_HI  = 4'h1;
  localparam logic [2:0] OP_ADC_MID = 3'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [3:0] hi;
    logic [2:0] mid;
    logic       dest;
    logic [7:0] faddr;
  } awfa_instr_t;
  typedef struct packed {
    logic ov_f;
    logic z_f;
    logic dc_f;
    logic c_f;
  } awfa_flags_t;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_DECODE = 5'h02,
    ST_READ   = 5'h04,
    ST_EXEC   = 5'h08,
    ST_WRITE  = 5'h10
  } awfa_state_t;
endpackage
`default_nettype wire

// ==== logic/awfa_core.sv ====
// Contract
// - plain add sums work and file, sets flags
// - plain add result to work or file
// - carry add sums work, file, carry; flags
// - carry add with select one writes file
// - carry add select zero writes work only
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module awfa_core #(
  parameter int FILE_DEPTH = 256
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ****************************************
  // state
  // ****************************************
  awfa_pkg::awfa_state_t state_reg;
  awfa_pkg::awfa_state_t state_next;
  awfa_pkg::awfa_instr_t instr_reg;
  awfa_pkg::awfa_flags_t flags_reg;
  logic [7:0]  work_reg;
  logic [7:0]  faddr_reg;
  logic [7:0]  operand_reg;
  logic [8:0]  sum_reg;
  logic        dc_reg;
  logic        bad_reg;
  logic [7:0]  file_mem [FILE_DEPTH];
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  // ****************************************
  // bus decode
  // ****************************************
  wire logic        busy      = (state_reg != awfa_pkg::ST_IDLE);
  wire logic        do_write  = ce && aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire logic [31:0] wmask     = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                                 {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire logic        hit_instr = (awaddr_reg == awfa_pkg::OFS_INSTR);
  wire logic        hit_work  = (awaddr_reg == awfa_pkg::OFS_WORK);
  wire logic        hit_flags = (awaddr_reg == awfa_pkg::OFS_FLAGS);
  wire logic        hit_faddr = (awaddr_reg == awfa_pkg::OFS_FADDR);
  wire logic        hit_fdata = (awaddr_reg == awfa_pkg::OFS_FDATA);
  wire logic        w_mapped  = hit_instr | hit_work | hit_flags | hit_faddr | hit_fdata;
  // software may not disturb operands while an instruction runs
  wire logic        w_ok      = do_write && w_mapped && (!busy || hit_faddr);
  wire logic [31:0] old_word  = hit_instr ? {16'h0000, instr_reg} :
                                hit_work  ? {24'h000000, work_reg} :
                                hit_flags ? {28'h0000000, flags_reg} :
                                hit_faddr ? {24'h000000, faddr_reg} :
                                {24'h000000, file_mem[faddr_reg]};
  wire logic [31:0] new_word  = (old_word & ~wmask) | (wdata_reg & wmask);
  wire logic        start     = w_ok && hit_instr;
  wire logic        ar_take   = s_axi_arvalid && s_axi_arready;
  wire logic [31:0] rd_word   =
    (s_axi_araddr == awfa_pkg::OFS_INSTR) ? {16'h0000, instr_reg} :
    (s_axi_araddr == awfa_pkg::OFS_WORK)  ? {24'h000000, work_reg} :
    (s_axi_araddr == awfa_pkg::OFS_FLAGS) ? {22'h00000, bad_reg, busy, 4'h0, flags_reg} :
    (s_axi_araddr == awfa_pkg::OFS_FADDR) ? {24'h000000, faddr_reg} :
    {24'h000000, file_mem[faddr_reg]};
  wire logic        r_mapped  = (s_axi_araddr == awfa_pkg::OFS_INSTR) |
                                (s_axi_araddr == awfa_pkg::OFS_WORK) |
                                (s_axi_araddr == awfa_pkg::OFS_FLAGS) |
                                (s_axi_araddr == awfa_pkg::OFS_FADDR) |
                                (s_axi_araddr == awfa_pkg::OFS_FDATA);
  assign s_axi_awready = ce && !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = ce && !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  // ****************************************
  // datapath
  // ****************************************
  wire logic is_add   = (instr_reg.hi == awfa_pkg::OP_ADD_HI) &&
                        (instr_reg.mid == awfa_pkg::OP_ADD_MID);
  wire logic is_adc   = (instr_reg.hi == awfa_pkg::OP_ADC_HI) &&
                        (instr_reg.mid == awfa_pkg::OP_ADC_MID);
  wire logic cin      = is_adc & flags_reg.c_f;
  wire logic [8:0] sum_next = {1'b0, work_reg} + {1'b0, operand_reg} + {8'h00, cin};
  wire logic [4:0] nib_sum  = {1'b0, work_reg[3:0]} + {1'b0, operand_reg[3:0]} + {4'h0, cin};
  wire logic [7:0] result   = sum_reg[7:0];
  wire awfa_pkg::awfa_flags_t flags_calc = '{
    ov_f: (work_reg[7] == operand_reg[7]) && (result[7] != work_reg[7]),
    z_f:  (result == 8'h00),
    dc_f: dc_reg,
    c_f:  sum_reg[8]
  };
  // select bit picks work or file for both adds
  wire logic to_file  = (state_reg == awfa_pkg::ST_WRITE) && instr_reg.dest;
  wire logic to_work  = (state_reg == awfa_pkg::ST_WRITE) && !instr_reg.dest;
  wire logic file_we  = to_file || (w_ok && hit_fdata);
  wire logic [7:0] file_wa = to_file ? instr_reg.faddr : faddr_reg;
  wire logic [7:0] file_wd = to_file ? result : new_word[7:0];
  // ****************************************
  // phase sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      awfa_pkg::ST_IDLE:   state_next = start ? awfa_pkg::ST_DECODE : awfa_pkg::ST_IDLE;
      awfa_pkg::ST_DECODE: state_next = (is_add || is_adc) ? awfa_pkg::ST_READ
                                                           : awfa_pkg::ST_IDLE;
      awfa_pkg::ST_READ:   state_next = awfa_pkg::ST_EXEC;
      awfa_pkg::ST_EXEC:   state_next = awfa_pkg::ST_WRITE;
      awfa_pkg::ST_WRITE:  state_next = awfa_pkg::ST_IDLE;
      default:             state_next = awfa_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= awfa_pkg::ST_IDLE;
    else if (ce)
      state_reg <= state_next;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr_reg   <= awfa_pkg::INSTR_RST;
      operand_reg <= 8'h00;
      sum_reg     <= 9'h000;
      dc_reg      <= 1'b0;
      faddr_reg   <= 8'h00;
    end
    else if (ce)
    begin
      if (start)
        instr_reg <= new_word[15:0];
      if (w_ok && hit_faddr)
        faddr_reg <= new_word[7:0];
      if (state_reg == awfa_pkg::ST_READ)
        operand_reg <= file_mem[instr_reg.faddr];
      if (state_reg == awfa_pkg::ST_EXEC)
      begin
        sum_reg <= sum_next;
        dc_reg  <= nib_sum[4];
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      work_reg  <= awfa_pkg::WORK_RST;
      flags_reg <= awfa_pkg::FLAGS_RST;
      bad_reg   <= 1'b0;
    end
    else if (ce)
    begin
      if (to_work)
        work_reg <= result;
      else if (w_ok && hit_work)
        work_reg <= new_word[7:0];
      if (state_reg == awfa_pkg::ST_WRITE)
        flags_reg <= flags_calc;
      else if (w_ok && hit_flags)
        flags_reg <= new_word[3:0];
      // set beats a clear in the same cycle
      if ((state_reg == awfa_pkg::ST_DECODE) && !is_add && !is_adc)
        bad_reg <= 1'b1;
      else if (w_ok && hit_flags && new_word[awfa_pkg::FLG_BAD])
        bad_reg <= 1'b0;
    end
  end
  // no reset on the file: it is data, not control
  always_ff @(posedge aclk)
  begin
    if (ce && file_we)
      file_mem[file_wa] <= file_wd;
  end
  // ****************************************
  // bus channels
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= awfa_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= w_ok ? awfa_pkg::RESP_OKAY : awfa_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= awfa_pkg::RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= r_mapped ? awfa_pkg::RESP_OKAY : awfa_pkg::RESP_SLVERR;
        rdata_reg  <= r_mapped ? rd_word : 32'h00000000;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  a_add_plain_sum: assert property ((state_reg == awfa_pkg::ST_WRITE) && is_add
    |-> result == work_reg + operand_reg) else $error("plain add sum wrong");
  a_adc_carry_sum: assert property ((state_reg == awfa_pkg::ST_WRITE) && is_adc
    |-> sum_reg == {1'b0, work_reg} + {1'b0, operand_reg} + {8'h00, flags_reg.c_f})
    else $error("carry add sum wrong");
  a_flags_update: assert property ((state_reg == awfa_pkg::ST_WRITE)
    |=> flags_reg.c_f == $past(sum_reg[8]) && flags_reg.z_f == ($past(result) == 8'h00))
    else $error("carry or zero flag wrong");
  a_dest_work_write: assert property (to_work
    |=> work_reg == $past(result)) else $error("work not written");
  a_dest_file_write: assert property (to_file
    |-> file_we && file_wa == instr_reg.faddr && file_wd == result)
    else $error("file not written");
  a_work_kept_file: assert property (to_file
    |=> $stable(work_reg)) else $error("work changed on file dest");
  a_file_kept_work: assert property (to_work |-> !file_we)
    else $error("file changed on work dest");
  a_phase_walk: assert property ((state_reg == awfa_pkg::ST_DECODE) && (is_add || is_adc)
    |=> (state_reg == awfa_pkg::ST_READ) ##1 (state_reg == awfa_pkg::ST_EXEC)
    ##1 (state_reg == awfa_pkg::ST_WRITE) ##1 (state_reg == awfa_pkg::ST_IDLE))
    else $error("phase order broken");
  a_bad_opcode: assert property ((state_reg == awfa_pkg::ST_DECODE) && !is_add && !is_adc
    |=> (state_reg == awfa_pkg::ST_IDLE) && bad_reg) else $error("bad opcode missed");
  c_add_to_work:  cover property (to_work && is_add);
  c_adc_to_file:  cover property (to_file && is_adc && flags_reg.c_f);
  c_bad_opcode:   cover property ((state_reg == awfa_pkg::ST_DECODE) && !is_add && !is_adc);
  c_refused_write: cover property (do_write && busy && !hit_faddr);
endmodule
`default_nettype wire

// ==== bench/awfa_ref_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// reference of work, file and flags
// ****************************************
module awfa_ref_model;
  int file_m [256];
  int work_m;
  int flags_m;
  // one call stands for the whole four-phase instruction
  task automatic exec(input int adc, input int dest, input int fa);
    int cin;
    int s;
    int d4;
    int r;
    int ov;
    cin = adc ? (flags_m % 2) : 0;
    s = work_m + file_m[fa] + cin;
    d4 = (work_m % 16) + (file_m[fa] % 16) + cin;
    r = s % 256;
    ov = ((work_m ^ r) & (file_m[fa] ^ r) & 128) != 0;
    flags_m = (s > 255) + 2 * (d4 > 15) + 4 * (r == 0) + 8 * ov;
    if (dest != 0)
      file_m[fa] = r;
    else
      work_m = r;
  endtask
endmodule
`default_nettype wire

// ==== bench/awfa_core_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module awfa_core_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  int          mismatches;
  int          checks;
  awfa_core uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  awfa_ref_model ref_m ();
  always #4 aclk = ~aclk;
  // ****************************************
  // bus tasks
  // ****************************************
  // bready and rready stay high, so no release can collide with the next request
  // no cycle count assumed: only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0]  r;
    do rd(awfa_pkg::OFS_FLAGS, d, r); while (d[awfa_pkg::FLG_BUSY] !== 1'b0);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] ins;
    int          fa;
    int          w;
    int          f;
    int          fl;
    int          wv[4];
    int          fv[4];
    wv = '{8'h17, 8'hFF, 8'h7F, 8'h80};
    fv = '{8'hC2, 8'h00, 8'h01, 8'h80};
    aclk = 1'b0;
    mismatches = 0;
    checks = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 4'h0;
    {ce, s_axi_bready, s_axi_rready} <= 3'h7;
    s_axi_wstrb <= 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(32'hAF38));
    rd(awfa_pkg::OFS_WORK, d, r);
    chk("work_rst", 32'(awfa_pkg::WORK_RST), d);
    rd(awfa_pkg::OFS_FLAGS, d, r);
    chk("flags_rst", 32'(awfa_pkg::FLAGS_RST), d);
    rd(8'h14, d, r);
    chk("unmapped_rd", 32'(awfa_pkg::RESP_SLVERR), 32'(r));
    wr(8'h14, 32'h1, r);
    chk("unmapped_wr", 32'(awfa_pkg::RESP_SLVERR), 32'(r));
    for (int i = 0; i < 16; i++)
    begin
      // first four carry fixed edge operands: carry chain, overflow, zero
      fa = $urandom % 256;
      w = (i < 4) ? wv[i] : $urandom % 256;
      f = (i < 4) ? fv[i] : $urandom % 256;
      fl = (i < 4) ? i % 2 : $urandom % 16;
      wr(awfa_pkg::OFS_FADDR, fa, r);
      wr(awfa_pkg::OFS_FDATA, f, r);
      wr(awfa_pkg::OFS_WORK, w, r);
      wr(awfa_pkg::OFS_FLAGS, fl, r);
      ref_m.file_m[fa] = f;
      ref_m.work_m = w;
      ref_m.flags_m = fl;
      if (i % 2 == 1)
        ins = {awfa_pkg::OP_ADC_HI, awfa_pkg::OP_ADC_MID, i[1], fa[7:0]};
      else
        ins = {awfa_pkg::OP_ADD_HI, awfa_pkg::OP_ADD_MID, i[1], fa[7:0]};
      wr(awfa_pkg::OFS_INSTR, {16'h0000, ins}, r);
      chk("instr_resp", 32'(awfa_pkg::RESP_OKAY), 32'(r));
      if (i == 5)
      begin
        wr(awfa_pkg::OFS_WORK, 32'h55, r);
        chk("busy_resp", 32'(awfa_pkg::RESP_SLVERR), 32'(r));
      end
      // freeze mid-instruction: readies drop, the run resumes where it stopped
      if (i == 7)
      begin
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("ce_freeze_rdy", 32'h0, {30'h0, s_axi_awready, s_axi_arready});
        ce <= 1'b1;
      end
      ref_m.exec(i % 2, (i / 2) % 2, fa);
      wait_idle();
      rd(awfa_pkg::OFS_WORK, d, r);
      chk("work", ref_m.work_m, d);
      rd(awfa_pkg::OFS_FLAGS, d, r);
      chk("flags", ref_m.flags_m, d);
      rd(awfa_pkg::OFS_FDATA, d, r);
      chk("file", ref_m.file_m[fa], d);
    end
    // byte lane 0 disabled: the working register must keep its value
    s_axi_wstrb <= 4'h2;
    wr(awfa_pkg::OFS_WORK, 32'(ref_m.work_m ^ 255), r);
    s_axi_wstrb <= 4'hF;
    rd(awfa_pkg::OFS_WORK, d, r);
    chk("strb_work", ref_m.work_m, d);
    wr(awfa_pkg::OFS_INSTR, 32'h0000F000, r);
    wait_idle();
    rd(awfa_pkg::OFS_FLAGS, d, r);
    chk("bad_flags", 32'h200 | ref_m.flags_m, d);
    rd(awfa_pkg::OFS_WORK, d, r);
    chk("bad_work", ref_m.work_m, d);
    wr(awfa_pkg::OFS_FLAGS, 32'h200, r);
    rd(awfa_pkg::OFS_FLAGS, d, r);
    chk("bad_clear", 32'h0, d);
    report_and_stop();
  end
endmodule
`default_nettype wire
